/* hw/pcc_pkg.sv */
// pcc_pkg: constants and carrier types for the configuration command,
// status and class block.
// assumes: config accesses arrive as one-cycle requests on the PCI clock.
package pcc_pkg;

	// --------------------------------------------------------------
	// offsets (byte addresses in configuration space)
	// --------------------------------------------------------------
	localparam logic [7:0]  CMD_OFFSET      = 8'h04;
	localparam logic [7:0]  STAT_OFFSET     = 8'h06;
	localparam logic [7:0]  CLASS_OFFSET    = 8'h08;

	// --------------------------------------------------------------
	// command field positions and values after reset
	// --------------------------------------------------------------
	localparam int          CMD_MEMORY_BIT  = 1;
	localparam int          CMD_MASTER_BIT  = 2;
	localparam int          CMD_MWI_BIT     = 4;
	localparam int          CMD_PERR_BIT    = 6;
	localparam int          CMD_SERR_BIT    = 8;
	localparam logic [15:0] CMD_RESET       = 16'h0000;

	// --------------------------------------------------------------
	// status field positions and values after reset
	// --------------------------------------------------------------
	localparam int          STAT_PARITY_BIT = 15;
	localparam int          STAT_SYSERR_BIT = 14;
	localparam int          STAT_INITIATOR_ABORT_FLAG_BIT = 13;
	localparam int          STAT_TASEEN_BIT = 12;
	localparam int          STAT_TASENT_BIT = 11;
	localparam int          STAT_DPAR_BIT   = 8;
	localparam logic [15:0] STAT_RESET      = 16'h0210;

	// --------------------------------------------------------------
	// class word fields
	// --------------------------------------------------------------
	localparam logic [7:0]  BASE_CATEGORY     = 8'h0C;
	localparam logic [7:0]  SUB_CATEGORY      = 8'h00;
	localparam logic [7:0]  PROGRAMMING_MODEL = 8'h10;

	// --------------------------------------------------------------
	// master write command codes
	// --------------------------------------------------------------
	localparam logic [3:0]  CMD_CODE_MWI    = 4'hF;
	localparam logic [3:0]  CMD_CODE_MEMWR  = 4'h7;

	// --------------------------------------------------------------
	// carrier types
	// --------------------------------------------------------------
	typedef struct packed {
		logic        valid;
		logic        write;
		logic [7:0]  addr;
		logic [3:0]  byteEn;
		logic [31:0] wrData;
	} pcc_cfg_req_type;

	typedef struct packed {
		logic        done;
		logic [31:0] rdData;
	} pcc_cfg_rsp_type;

	typedef struct packed {
		logic dataParityErr;
		logic addrParityErr;
		logic masterPerrSeen;
		logic masterAbort;
		logic targetAbortSeen;
		logic targetAbortSent;
	} pcc_events_type;

	typedef struct packed {
		logic parity_fault_flag;
		logic system_fault_flag;
		logic initiator_abort_flag;
		logic target_abort_seen_flag;
		logic target_abort_sent_flag;
		logic data_parity_reported;
	} pcc_flags_type;

	typedef struct packed {
		logic serrOut;
		logic serrOeN;
		logic perrOut;
		logic perrOeN;
	} pcc_pins_type;

	typedef struct packed {
		logic       bus_initiator_on;
		logic       memory_target_on;
		logic [3:0] writeCommand;
		logic       ioClaimAllowed;
		logic       specialCycleAllowed;
	} pcc_ctrl_type;

	typedef struct packed {
		logic stage1;
		logic stage2;
	} pcc_rsync_type;

endpackage

/* hw/pcc_reset_sync.sv */
// pcc_reset_sync: releases the asynchronous reset through two flops.
// assumes: arst_n may drop at any time; release is made synchronous.
`timescale 1ns/100ps
module pcc_reset_sync (
	input  wire logic clk,
	input  wire logic arst_n,
	output logic      rstSync_n
);
	pcc_pkg::pcc_rsync_type st_q;
	pcc_pkg::pcc_rsync_type st_d;

	// first stage feeds only the second stage
	always_comb begin
		st_d.stage1 = 1'b1;
		st_d.stage2 = st_q.stage1;
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign rstSync_n = st_q.stage2;
endmodule

/* hw/pcc_flag_bank.sv */
// pcc_flag_bank: sticky error flags, set by hardware, cleared by a one.
// assumes: set and clear arrive as one-cycle masks on the same clock.
`timescale 1ns/100ps
module pcc_flag_bank (
	input  wire logic                  clk,
	input  wire logic                  rst_n,
	input  wire pcc_pkg::pcc_flags_type setMask,
	input  wire pcc_pkg::pcc_flags_type clrMask,
	output pcc_pkg::pcc_flags_type     flags
);
	localparam int N = $bits(pcc_pkg::pcc_flags_type);

	pcc_pkg::pcc_flags_type st_q;
	pcc_pkg::pcc_flags_type st_d;
	logic [N-1:0]           nextVec;

	// set beats clear so a recurring event is never lost
	for (genvar i = 0; i < N; i++) begin : g_flag
		assign nextVec[i] = setMask[i] | (st_q[i] & ~clrMask[i]);
	end

	always_comb begin
		st_d = pcc_pkg::pcc_flags_type'(nextVec);
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign flags = st_q;
endmodule

/* hw/pcc_config_regs.sv */
// pcc_config_regs: command, status and class words of the configuration
// header, with the controls and error pins they steer.
// assumes: a target decoder presents config cycles as one-cycle requests;
// events are one-cycle pulses from the bus engine on the same clock.
//
// Summary of operation
// - command bits 15:10 read zero, writes ignored
// - no fast back-to-back; command bit 9 reads zero
// - bit 8 enables the system error driver for address parity errors
// - no stepping; command bit 7 hardwired zero
// - parity error pin driven only while bit 6 is set
// - no palette snooping; command bit 5 reads zero
// - bit 4 picks write-and-invalidate, else plain memory write
// - special cycles ignored; command bit 3 reads zero
// - master cycles only while bit 2 is set
// - memory cycles answered only while bit 1 is set
// - no I/O space; bit 0 reads zero, I/O cycles never claimed
// - status at 06h resets to 0210h; error flags set by hardware
// - writing one clears a status flag, zero leaves it
// - class bits 31:24 read 0Ch
// - class bits 23:16 read 00h
// - class bits 15:8 read 10h
// - class bits 7:0 give the read-only silicon stepping
`timescale 1ns/100ps
module pcc_config_regs #(
	// arbitrary value; set per stepping at tape-out
	parameter logic [7:0] SILICON_STEPPING = 8'h01
) (
	input  wire logic                    clk,
	input  wire logic                    arst_n,
	input  wire pcc_pkg::pcc_cfg_req_type cfgReq,
	output pcc_pkg::pcc_cfg_rsp_type     cfgRsp,
	input  wire pcc_pkg::pcc_events_type busEvents,
	output pcc_pkg::pcc_ctrl_type        busCtrl,
	output pcc_pkg::pcc_pins_type        errPins
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic                     system_error_drive_on;
		logic                     parity_response_on;
		logic                     write_invalidate_on;
		logic                     bus_initiator_on;
		logic                     memory_target_on;
		pcc_pkg::pcc_cfg_rsp_type rsp;
		pcc_pkg::pcc_ctrl_type    ctrl;
		pcc_pkg::pcc_pins_type    pins;
	} pcc_main_state_type;

	pcc_main_state_type     st_q;
	pcc_main_state_type     st_d;
	logic                   rst_n;
	pcc_pkg::pcc_flags_type flags;
	pcc_pkg::pcc_flags_type flagSet;
	pcc_pkg::pcc_flags_type flagClr;
	logic [15:0]            cmdWord;
	logic [15:0]            statWord;
	logic [31:0]            classWord;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// dword match; the low two address bits only pick byte lanes
	function automatic logic hitDword(input logic [7:0] addr, input logic [7:0] offs);
		hitDword = (addr[7:2] == offs[7:2]);
	endfunction

	// ----------------------------------------------------------------
	// reset release and flag storage
	// ----------------------------------------------------------------
	pcc_reset_sync u_rsync (
		.clk       (clk),
		.arst_n    (arst_n),
		.rstSync_n (rst_n)
	);

	pcc_flag_bank u_flags (
		.clk     (clk),
		.rst_n   (rst_n),
		.setMask (flagSet),
		.clrMask (flagClr),
		.flags   (flags)
	);

	// ----------------------------------------------------------------
	// read views
	// ----------------------------------------------------------------
	always_comb begin
		cmdWord                 = pcc_pkg::CMD_RESET;
		cmdWord[pcc_pkg::CMD_SERR_BIT]   = st_q.system_error_drive_on;
		cmdWord[pcc_pkg::CMD_PERR_BIT]   = st_q.parity_response_on;
		cmdWord[pcc_pkg::CMD_MWI_BIT]    = st_q.write_invalidate_on;
		cmdWord[pcc_pkg::CMD_MASTER_BIT] = st_q.bus_initiator_on;
		cmdWord[pcc_pkg::CMD_MEMORY_BIT] = st_q.memory_target_on;
	end

	// fixed speed and capability bits come from the reset image
	always_comb begin
		statWord = pcc_pkg::STAT_RESET;
		statWord[pcc_pkg::STAT_PARITY_BIT] = flags.parity_fault_flag;
		statWord[pcc_pkg::STAT_SYSERR_BIT] = flags.system_fault_flag;
		statWord[pcc_pkg::STAT_INITIATOR_ABORT_FLAG_BIT] = flags.initiator_abort_flag;
		statWord[pcc_pkg::STAT_TASEEN_BIT] = flags.target_abort_seen_flag;
		statWord[pcc_pkg::STAT_TASENT_BIT] = flags.target_abort_sent_flag;
		statWord[pcc_pkg::STAT_DPAR_BIT]   = flags.data_parity_reported;
	end

	always_comb begin
		classWord[31:24] = pcc_pkg::BASE_CATEGORY;
		classWord[23:16] = pcc_pkg::SUB_CATEGORY;
		classWord[15:8]  = pcc_pkg::PROGRAMMING_MODEL;
		classWord[7:0]   = SILICON_STEPPING;
	end

	// ----------------------------------------------------------------
	// flag clearing and setting
	// ----------------------------------------------------------------
	always_comb begin
		flagClr = '0;
		if (cfgReq.valid && cfgReq.write && hitDword(cfgReq.addr, pcc_pkg::STAT_OFFSET)) begin
			if (cfgReq.byteEn[3]) begin
				flagClr.parity_fault_flag      = cfgReq.wrData[16 + pcc_pkg::STAT_PARITY_BIT];
				flagClr.system_fault_flag      = cfgReq.wrData[16 + pcc_pkg::STAT_SYSERR_BIT];
				flagClr.initiator_abort_flag   = cfgReq.wrData[16 + pcc_pkg::STAT_INITIATOR_ABORT_FLAG_BIT];
				flagClr.target_abort_seen_flag = cfgReq.wrData[16 + pcc_pkg::STAT_TASEEN_BIT];
				flagClr.target_abort_sent_flag = cfgReq.wrData[16 + pcc_pkg::STAT_TASENT_BIT];
				flagClr.data_parity_reported   = cfgReq.wrData[16 + pcc_pkg::STAT_DPAR_BIT];
			end
		end
	end

	// parity faults are logged whatever the enables; reporting is gated
	always_comb begin
		flagSet = '0;
		flagSet.parity_fault_flag      = busEvents.dataParityErr | busEvents.addrParityErr;
		flagSet.system_fault_flag      = busEvents.addrParityErr &
		                                 st_q.system_error_drive_on;
		flagSet.initiator_abort_flag   = busEvents.masterAbort;
		flagSet.target_abort_seen_flag = busEvents.targetAbortSeen;
		flagSet.target_abort_sent_flag = busEvents.targetAbortSent;
		flagSet.data_parity_reported   = busEvents.masterPerrSeen &
		                                 st_q.parity_response_on;
	end

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		st_d = st_q;
		st_d.rsp.done = 1'b0;

		// every access completes; read-only lanes just drop the data
		if (cfgReq.valid) begin
			st_d.rsp.done   = 1'b1;
			st_d.rsp.rdData = '0;
			if (cfgReq.write) begin
				if (hitDword(cfgReq.addr, pcc_pkg::CMD_OFFSET)) begin
					if (cfgReq.byteEn[1]) begin
						st_d.system_error_drive_on = cfgReq.wrData[pcc_pkg::CMD_SERR_BIT];
					end
					if (cfgReq.byteEn[0]) begin
						st_d.parity_response_on  = cfgReq.wrData[pcc_pkg::CMD_PERR_BIT];
						st_d.write_invalidate_on = cfgReq.wrData[pcc_pkg::CMD_MWI_BIT];
						st_d.bus_initiator_on    = cfgReq.wrData[pcc_pkg::CMD_MASTER_BIT];
						st_d.memory_target_on    = cfgReq.wrData[pcc_pkg::CMD_MEMORY_BIT];
					end
				end
			end else begin
				if (hitDword(cfgReq.addr, pcc_pkg::CMD_OFFSET)) begin
					st_d.rsp.rdData = {statWord, cmdWord};
				end else if (hitDword(cfgReq.addr, pcc_pkg::CLASS_OFFSET)) begin
					st_d.rsp.rdData = classWord;
				end
			end
		end

		// controls follow the new command value in the same edge
		st_d.ctrl.bus_initiator_on    = st_d.bus_initiator_on;
		st_d.ctrl.memory_target_on    = st_d.memory_target_on;
		st_d.ctrl.writeCommand        = st_d.write_invalidate_on ?
		                                pcc_pkg::CMD_CODE_MWI : pcc_pkg::CMD_CODE_MEMWR;
		st_d.ctrl.ioClaimAllowed      = 1'b0;
		st_d.ctrl.specialCycleAllowed = 1'b0;

		// open-drain error pins: low enable means this end pulls low
		st_d.pins.serrOut = 1'b0;
		st_d.pins.perrOut = 1'b0;
		st_d.pins.serrOeN = ~(busEvents.addrParityErr & st_q.system_error_drive_on);
		st_d.pins.perrOeN = ~(busEvents.dataParityErr & st_q.parity_response_on);
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q                          <= '0;
			st_q.ctrl.writeCommand        <= pcc_pkg::CMD_CODE_MEMWR;
			st_q.pins.serrOeN             <= 1'b1;
			st_q.pins.perrOeN             <= 1'b1;
		end else begin
			st_q <= st_d;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign cfgRsp  = st_q.rsp;
	assign busCtrl = st_q.ctrl;
	assign errPins = st_q.pins;

endmodule

/* bench/pcc_config_regs_checker.sv */
// pcc_config_regs_checker: port-level properties of the config block.
// assumes: bound to pcc_config_regs, one clock domain.
`timescale 1ns/100ps
module pcc_config_regs_checker (
	input wire logic                     clk,
	input wire logic                     arst_n,
	input wire pcc_pkg::pcc_cfg_req_type cfgReq,
	input wire pcc_pkg::pcc_cfg_rsp_type cfgRsp,
	input wire pcc_pkg::pcc_events_type  busEvents,
	input wire pcc_pkg::pcc_ctrl_type    busCtrl,
	input wire pcc_pkg::pcc_pins_type    errPins
);
	logic [1:0]  rdKind_q;
	logic [31:0] wrData_q;
	logic        cmdWr;
	// shadow of the two error enables, tracked from command writes
	logic        serrEn_q;
	logic        perrEn_q;
	assign cmdWr = cfgReq.valid && cfgReq.write && cfgReq.addr[7:2] == 6'h01 && cfgReq.byteEn[0];
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rdKind_q <= 2'h0;
			wrData_q <= 32'h0;
			serrEn_q <= 1'b0;
			perrEn_q <= 1'b0;
		end else begin
			if (cmdWr) begin
				perrEn_q <= cfgReq.wrData[6];
			end
			if (cfgReq.valid && cfgReq.write && cfgReq.addr[7:2] == 6'h01 && cfgReq.byteEn[1]) begin
				serrEn_q <= cfgReq.wrData[8];
			end
			rdKind_q <= {cfgReq.valid && !cfgReq.write && cfgReq.addr[7:2] == 6'h02,
				cfgReq.valid && !cfgReq.write && cfgReq.addr[7:2] == 6'h01};
			wrData_q <= cfgReq.wrData;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);
	AST_DONE_FOLLOWS: assert property (cfgReq.valid |=> cfgRsp.done)
		else $error("done missing after request");
	AST_DONE_CAUSE: assert property (cfgRsp.done |-> $past(cfgReq.valid))
		else $error("done without request");
	AST_CMD_ZERO: assert property (cfgRsp.done && rdKind_q[0] |-> (cfgRsp.rdData & 32'h0000FEA9) == 32'h0)
		else $error("hardwired command bit read nonzero");
	AST_STAT_FIXED: assert property (cfgRsp.done && rdKind_q[0] |-> (cfgRsp.rdData[31:16] & 16'h06FF) == 16'h0210)
		else $error("fixed status bits wrong");
	AST_CLASS: assert property (cfgRsp.done && rdKind_q[1] |-> cfgRsp.rdData[31:8] == {pcc_pkg::BASE_CATEGORY, pcc_pkg::SUB_CATEGORY, pcc_pkg::PROGRAMMING_MODEL})
		else $error("class word wrong");
	AST_WRCMD: assert property (cmdWr |=> busCtrl.writeCommand == (wrData_q[4] ? pcc_pkg::CMD_CODE_MWI : pcc_pkg::CMD_CODE_MEMWR))
		else $error("write command code wrong");
	AST_MASTER: assert property (cmdWr |=> busCtrl.bus_initiator_on == wrData_q[2] && busCtrl.memory_target_on == wrData_q[1])
		else $error("master or memory enable wrong");
	AST_NO_IO: assert property (!busCtrl.ioClaimAllowed && !busCtrl.specialCycleAllowed)
		else $error("io or special cycle claimed");
	AST_SERR: assert property (!errPins.serrOeN |-> !errPins.serrOut &&
		$past(busEvents.addrParityErr) && $past(serrEn_q))
		else $error("serr driven without cause");
	AST_SERR_DRIVE: assert property (busEvents.addrParityErr && serrEn_q |=> !errPins.serrOeN)
		else $error("serr not driven for enabled address parity error");
	AST_PERR: assert property (!errPins.perrOeN |-> !errPins.perrOut &&
		$past(busEvents.dataParityErr) && $past(perrEn_q))
		else $error("perr driven without cause");
	AST_PERR_DRIVE: assert property (busEvents.dataParityErr && perrEn_q |=> !errPins.perrOeN)
		else $error("perr not driven for enabled data parity error");
	cover property (cmdWr);
	cover property (!errPins.serrOeN);
	cover property (!errPins.perrOeN);
	cover property (cfgRsp.done && rdKind_q[1]);
endmodule
bind pcc_config_regs pcc_config_regs_checker pcc_config_regs_checker_inst (.clk(clk), .arst_n(arst_n), .cfgReq(cfgReq), .cfgRsp(cfgRsp), .busEvents(busEvents), .busCtrl(busCtrl), .errPins(errPins));

/* bench/pcc_host_model.sv */
// pcc_host_model: host bridge issuing configuration cycles.
// assumes: one-cycle request pulse, done one cycle later.
`timescale 1ns/100ps
module pcc_host_model (
	input wire logic                     clk,
	output pcc_pkg::pcc_cfg_req_type     cfgReq,
	input wire pcc_pkg::pcc_cfg_rsp_type cfgRsp
);
	initial cfgReq = '{1'b0, 1'b0, 8'hA5, 4'h5, 32'h5A5AA5A5};
	task automatic cfg(input logic wr, input logic [7:0] a, input logic [3:0] be,
		input logic [31:0] d, output logic [31:0] rd, output logic ok);
		int n;
		ok = 1'b0;
		rd = 32'h0;
		@(negedge clk);
		cfgReq = '{1'b1, wr, a, be, d};
		@(negedge clk);
		// released lines carry inverted junk, never the stale value
		cfgReq = '{1'b0, ~wr, ~a, ~be, ~d};
		for (n = 0; n < 4 && !ok; n++) begin
			if (cfgRsp.done === 1'b1) begin
				ok = 1'b1;
				rd = cfgRsp.rdData;
			end else @(negedge clk);
		end
	endtask
endmodule

/* bench/pcc_config_regs_tb.sv */
// pcc_config_regs_tb: self-checking bench for the config block.
// assumes: host model drives config cycles, bench drives events.
`timescale 1ns/100ps
module pcc_config_regs_tb;
	localparam logic [7:0] STEP = 8'h3C; // arbitrary stepping value
	logic                     clk;
	logic                     arst_n;
	pcc_pkg::pcc_cfg_req_type cfgReq;
	pcc_pkg::pcc_cfg_rsp_type cfgRsp;
	pcc_pkg::pcc_events_type  events;
	pcc_pkg::pcc_ctrl_type    ctrl;
	pcc_pkg::pcc_pins_type    pins;
	int                       mismatches;
	int                       samples_checked;
	logic [31:0]              rd;
	logic                     ok;
	pcc_config_regs #(.SILICON_STEPPING(STEP)) pcc_config_regs_inst (.clk(clk), .arst_n(arst_n),
		.cfgReq(cfgReq), .cfgRsp(cfgRsp), .busEvents(events), .busCtrl(ctrl), .errPins(pins));
	pcc_host_model pcc_host_model_inst (.clk(clk), .cfgReq(cfgReq), .cfgRsp(cfgRsp));
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	task automatic stop_test();
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	// int direction flag so plain 0/1 at the call sites carries no truncation
	task automatic acc(input int wr, input logic [7:0] a, input logic [3:0] be,
		input logic [31:0] d);
		pcc_host_model_inst.cfg(wr[0], a, be, d, rd, ok);
		if (ok !== 1'b1) begin
			mismatches++;
			$display("[FAIL] done expected 1 seen %b", ok);
			stop_test();
		end
	endtask
	// one event pulse, then watch both error enables for four cycles
	task automatic pulse(input logic [5:0] e, input logic expS, input logic expP);
		logic sLow;
		logic pLow;
		sLow = 1'b0;
		pLow = 1'b0;
		@(negedge clk);
		events = e;
		@(negedge clk);
		events = '0;
		repeat (4) begin
			sLow |= (pins.serrOeN === 1'b0);
			pLow |= (pins.perrOeN === 1'b0);
			@(negedge clk);
		end
		chk("serr low", 32'(expS), 32'(sLow));
		chk("perr low", 32'(expP), 32'(pLow));
	endtask
	task automatic t_reset();
		acc(0, 8'h04, 4'hF, 0);
		chk("cmd status", 32'h02100000, rd);
		acc(0, 8'h08, 4'hF, 0);
		chk("class", {24'h0C0010, STEP}, rd);
		acc(1, 8'h08, 4'hF, 32'hFFFFFFFF);
		acc(0, 8'h08, 4'hF, 0);
		chk("class kept", {24'h0C0010, STEP}, rd);
		acc(0, 8'h0C, 4'hF, 0);
		chk("unmapped", 32'h0, rd);
		chk("ctrl", 32'h1C, 32'(ctrl));
	endtask
	task automatic t_command();
		acc(1, 8'h04, 4'h3, 32'h0000FFFF);
		acc(0, 8'h04, 4'hF, 0);
		chk("cmd all ones", 32'h02100156, rd);
		chk("ctrl on", 32'hFC, 32'(ctrl));
		acc(1, 8'h04, 4'h1, 32'hFFFF0000);
		acc(0, 8'h04, 4'hF, 0);
		chk("cmd lane0 only", 32'h02100100, rd);
		chk("ctrl off", 32'h1C, 32'(ctrl));
	endtask
	task automatic t_events();
		acc(1, 8'h04, 4'h3, 32'h00000140);
		pulse(6'h3F, 1'b1, 1'b1);
		acc(0, 8'h04, 4'hF, 0);
		chk("flags set", 32'hFB100140, rd);
		acc(1, 8'h04, 4'hC, 32'h80FF0000);
		acc(0, 8'h04, 4'hF, 0);
		chk("parity cleared", 32'h7B100140, rd);
		acc(1, 8'h04, 4'h8, 32'h79000000);
		acc(0, 8'h04, 4'hF, 0);
		chk("all cleared", 32'h02100140, rd);
		acc(1, 8'h04, 4'h3, 32'h0);
		pulse(6'h38, 1'b0, 1'b0);
		acc(0, 8'h04, 4'hF, 0);
		chk("gated flags", 32'h82100000, rd);
	endtask
	// reset in mid-run with a flag and command bits set; all return to reset image
	task automatic t_rereset();
		acc(1, 8'h04, 4'h3, 32'h00000156);
		@(negedge clk);
		arst_n = 1'b0;
		repeat (2) @(negedge clk);
		chk("ctrl in reset", 32'h1C, 32'(ctrl));
		chk("serr oe in reset", 32'h1, 32'(pins.serrOeN));
		chk("perr oe in reset", 32'h1, 32'(pins.perrOeN));
		arst_n = 1'b1;
		repeat (3) @(negedge clk);
		acc(0, 8'h04, 4'hF, 0);
		chk("cmd status after reset", 32'h02100000, rd);
		chk("ctrl after reset", 32'h1C, 32'(ctrl));
	endtask
	initial begin
		mismatches = 0;
		samples_checked = 0;
		arst_n = 1'b0;
		events = '0;
		repeat (16) @(negedge clk);
		arst_n = 1'b1;
		repeat (3) @(negedge clk);
		t_reset();
		t_command();
		t_events();
		t_rereset();
		stop_test();
	end
endmodule
